/* File: design/upps_port.sv */
// Card-side parallel port of a host-facing UART, with APB host registers.
//
// Chosen here: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "upps_consts.svh"
// Functional notes
// - Parallel mode bypasses serial, uses buffers directly.
// - FIFO mode: status low only on full.
// - FIFO mode: pulse when transmit FIFO fills.
// - Status released after first byte read.
// - Status release 150 ns plus one period.
// - Acknowledge strobe is edge sensitive, pulsed.
// - Receive byte captured at strobe release.
// - Data ready set only after strobe release.
// - Controller writes up to sixteen bytes.
// - FIFO mode: pulse when receive FIFO empties.
// - Non-FIFO mode moves single bytes per handshake.
// - Side-band mode shows last transmitted character.
// - Side-band lines reset to zero.
// - Side-band lines pass only under condition.
// - Side-band still sends serially, character rate.
// - Word length code selects five to eight.
// - Stop select gives 1.5 or 2.
// - Data ready also set by parallel writes.
// - Parallel mode: TX_ALL_EMPTY mirrors TX_HOLDING_EMPTY, errors zero.
module upps_port
    import upps_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    input  wire logic [7:0]  pp_data_in,
    output var  logic [7:0]  pp_data_lines,
    output var  logic        pp_data_oe_n,
    output var  logic        pp_status_n,
    output var  logic        pp_irq_pulse_n,
    input  wire logic        pp_tx_ack_n,
    input  wire logic        pp_rx_wr_n,
    output var  logic        ser_tx_valid,
    output var  logic [7:0]  ser_tx_data,
    input  wire logic        ser_tx_take,
    input  wire logic        ser_tx_idle,
    input  wire logic        ser_rx_valid,
    input  wire logic [7:0]  ser_rx_data,
    input  wire logic [3:0]  ser_err,
    output var  logic [3:0]  ser_word_bits,
    output var  logic [1:0]  ser_stop_code
);
    upps_fifo_if tx ();
    upps_fifo_if rx ();

    logic [31:0]       prdata_ff;
    logic              pready_ff;
    logic              pslverr_ff;
    logic [2:0]        lctrl_ff;
    logic [2:0]        mode_ff;
    logic [3:0]        err_ff;
    logic [9:0]        sync1_ff;
    logic [9:0]        sync2_ff;
    logic [1:0]        strb_q_ff;
    upps_tx_st_t       tx_st_ff;
    logic [2:0]        t3_cnt_ff;
    logic              status_n_ff;
    logic              irq_n_ff;
    logic              tx_full_q_ff;
    logic              rx_empty_q_ff;
    logic [7:0]        sb_ff;
    logic [7:0]        pp_out_ff;
    logic              pp_oe_n_ff;
    logic              stx_valid_ff;
    logic [7:0]        stx_data_ff;
    logic [3:0]        word_bits_ff;
    logic [1:0]        stop_code_ff;
    logic              pp_mode;
    logic              extf_mode;
    logic              fifo_mode;
    logic              setup;
    logic              access;
    logic              addr_ok;
    logic              ack_fall;
    logic              wr_rise;
    logic              tx_pp_pop;
    logic              stx_load;
    logic              sb_cond;
    logic              tx_full_rise;
    logic              rx_empty_rise;
    logic [7:0]        lstat;
    logic [31:0]       rd_mux;

    upps_fifo u_tx_fifo (
        .pclk    (pclk),
        .presetn (presetn),
        .fif     (tx.mem)
    );

    upps_fifo u_rx_fifo (
        .pclk    (pclk),
        .presetn (presetn),
        .fif     (rx.mem)
    );

    assign pp_mode   = mode_ff[`UPPS_MD_PP];
    assign extf_mode = mode_ff[`UPPS_MD_EXTF];
    assign fifo_mode = mode_ff[`UPPS_MD_FIFO];
    assign setup     = psel && !penable;
    assign access    = psel && penable && pready_ff;
    assign addr_ok   = (paddr == `UPPS_ADDR_DATA) || (paddr == `UPPS_ADDR_LCTRL) ||
                       (paddr == `UPPS_ADDR_LSTAT) || (paddr == `UPPS_ADDR_MODE);

    // Strobes and data from the controller pass two flops; the strobe edge is taken past the second.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_ff  <= 10'h300;
            sync2_ff  <= 10'h300;
            strb_q_ff <= 2'h3;
        end else begin
            sync1_ff  <= {pp_rx_wr_n, pp_tx_ack_n, pp_data_in};
            sync2_ff  <= sync1_ff;
            strb_q_ff <= sync2_ff[9:8];
        end
    end

    assign ack_fall = strb_q_ff[0] && !sync2_ff[8];
    assign wr_rise  = !strb_q_ff[1] && sync2_ff[9];

    // one byte deep outside FIFO mode
    assign tx.lim = fifo_mode ? `UPPS_LIM_FIFO : `UPPS_LIM_BYTE;
    // sixteen receive bytes in FIFO mode
    assign rx.lim = fifo_mode ? `UPPS_LIM_FIFO : `UPPS_LIM_BYTE;

    // parallel side replaces the serial engine
    assign stx_load = !pp_mode && !tx.empty && (!stx_valid_ff || ser_tx_take);
    assign tx.push  = access && pwrite && (paddr == `UPPS_ADDR_DATA);
    assign tx.wdata = pwdata[7:0];
    assign tx.pop   = pp_mode ? tx_pp_pop : stx_load;
    // parallel writes fill the receive side
    assign rx.push  = pp_mode ? wr_rise : ser_rx_valid;
    assign rx.wdata = pp_mode ? sync2_ff[7:0] : ser_rx_data;
    assign rx.pop   = access && !pwrite && (paddr == `UPPS_ADDR_DATA);

    assign tx_full_rise  = tx.full && !tx_full_q_ff;
    assign rx_empty_rise = rx.empty && !rx_empty_q_ff;
    assign tx_pp_pop     = (tx_st_ff == UPPS_TX_DELAY) && (t3_cnt_ff == 3'h0);

    // data ready is the FIFO level, which in parallel mode only rises on strobe release
    // TX_ALL_EMPTY mirrors TX_HOLDING_EMPTY and error bits read zero in parallel mode
    always_comb begin
        lstat                                  = 8'h00;
        lstat[`UPPS_LS_RD]                     = !rx.empty;
        lstat[`UPPS_LS_ERR_HI:`UPPS_LS_ERR_LO] = pp_mode ? 4'h0 : err_ff;
        lstat[`UPPS_LS_TX_HOLDING_EMPTY]                   = tx.empty;
        lstat[`UPPS_LS_TX_ALL_EMPTY]                   = pp_mode ? tx.empty :
                                                 (tx.empty && !stx_valid_ff && ser_tx_idle);
    end

    always_comb begin
        rd_mux = 32'h0;
        unique case (paddr)
            `UPPS_ADDR_DATA:  rd_mux = {24'h0, rx.head};
            `UPPS_ADDR_LCTRL: rd_mux = {29'h0, lctrl_ff};
            `UPPS_ADDR_LSTAT: rd_mux = {24'h0, lstat};
            `UPPS_ADDR_MODE:  rd_mux = {29'h0, mode_ff};
            default:          rd_mux = 32'h0;
        endcase
    end

    // The slave answers in the first access cycle; ready is a flop so the setup cycle is never ready.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0;
        end else begin
            pready_ff  <= setup;
            pslverr_ff <= setup && !addr_ok;
            if (setup) begin
                prdata_ff <= pwrite ? 32'h0 : rd_mux;
            end
        end
    end

    // mode selects are clocked configuration bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lctrl_ff <= `UPPS_LC_RESET;
            mode_ff  <= `UPPS_MD_RESET;
        end else if (access && pwrite) begin
            if (paddr == `UPPS_ADDR_LCTRL) begin
                lctrl_ff <= pwdata[2:0];
            end
            if (paddr == `UPPS_ADDR_MODE) begin
                mode_ff <= pwdata[2:0];
            end
        end
    end

    // Serial error flags are sticky until a status read; a new error in that cycle wins.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err_ff <= 4'h0;
        end else begin
            err_ff <= ((access && !pwrite && (paddr == `UPPS_ADDR_LSTAT)) ? 4'h0 : err_ff) | ser_err;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            word_bits_ff <= `UPPS_WORD_BASE;
            stop_code_ff <= 2'h0;
        end else begin
            word_bits_ff <= `UPPS_WORD_BASE + {2'h0, lctrl_ff[`UPPS_LC_WLS_HI:`UPPS_LC_WLS_LO]};
            stop_code_ff <= !lctrl_ff[`UPPS_LC_NSB] ? 2'h0 :
                            (lctrl_ff[`UPPS_LC_WLS_HI:`UPPS_LC_WLS_LO] == 2'h0) ? 2'h1 : 2'h2;
        end
    end

    // Hand-off stage toward the serial engine, which stays idle in parallel mode.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stx_valid_ff <= 1'b0;
            stx_data_ff  <= 8'h00;
        end else if (stx_load) begin
            stx_valid_ff <= 1'b1;
            stx_data_ff  <= tx.head;
        end else if (ser_tx_take) begin
            stx_valid_ff <= 1'b0;
        end
    end

    assign sb_cond = !lctrl_ff[`UPPS_LC_WLS_HI] && !lctrl_ff[`UPPS_LC_WLS_LO] &&
                     lctrl_ff[`UPPS_LC_NSB] && !pp_mode && !extf_mode;

    // opens only under the condition and otherwise holds
    // follows each character as the serial engine takes it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sb_ff <= `UPPS_SB_RESET;
        end else if (sb_cond && ser_tx_take && stx_valid_ff) begin
            sb_ff <= stx_data_ff;
        end
    end

    // FIFO mode waits for a full FIFO
    // byte mode presents any held byte
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_st_ff  <= UPPS_TX_IDLE;
            t3_cnt_ff <= 3'h0;
        end else if (!pp_mode) begin
            tx_st_ff <= UPPS_TX_IDLE;
        end else begin
            unique case (tx_st_ff)
                UPPS_TX_IDLE: begin
                    if (fifo_mode ? tx_full_rise : !tx.empty) begin
                        tx_st_ff <= UPPS_TX_ARM;
                    end
                end
                UPPS_TX_ARM: begin
                    tx_st_ff <= UPPS_TX_WAIT;
                end
                UPPS_TX_WAIT: begin
                    if (ack_fall) begin
                        tx_st_ff  <= UPPS_TX_DELAY;
                        t3_cnt_ff <= `UPPS_T3_LOAD;
                    end
                end
                UPPS_TX_DELAY: begin
                    if (t3_cnt_ff != 3'h0) begin
                        t3_cnt_ff <= t3_cnt_ff - 3'h1;
                    end else if (fifo_mode && (tx.count > `UPPS_LIM_BYTE)) begin
                        tx_st_ff <= UPPS_TX_WAIT;
                    end else begin
                        tx_st_ff <= UPPS_TX_IDLE;
                    end
                end
            endcase
        end
    end

    // released with the first read byte
    // release follows the strobe by the timed delay
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_n_ff <= 1'b1;
        end else if (!pp_mode || tx_pp_pop) begin
            status_n_ff <= 1'b1;
        end else if (tx_st_ff == UPPS_TX_ARM) begin
            status_n_ff <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_full_q_ff  <= 1'b0;
            rx_empty_q_ff <= 1'b1;
            irq_n_ff      <= 1'b1;
        end else begin
            tx_full_q_ff  <= tx.full;
            rx_empty_q_ff <= rx.empty;
            irq_n_ff      <= !(pp_mode && fifo_mode && (tx_full_rise || rx_empty_rise));
        end
    end

    // Data leads the status edge by one cycle so it is stable before status falls.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pp_out_ff  <= `UPPS_SB_RESET;
            pp_oe_n_ff <= 1'b1;
        end else begin
            pp_out_ff  <= pp_mode ? tx.head : sb_ff;
            pp_oe_n_ff <= pp_mode ? (tx_st_ff == UPPS_TX_IDLE) : extf_mode;
        end
    end

    assign prdata         = prdata_ff;
    assign pready         = pready_ff;
    assign pslverr        = pslverr_ff;
    assign pp_data_lines  = pp_out_ff;
    assign pp_data_oe_n   = pp_oe_n_ff;
    assign pp_status_n    = status_n_ff;
    assign pp_irq_pulse_n = irq_n_ff;
    assign ser_tx_valid   = stx_valid_ff;
    assign ser_tx_data    = stx_data_ff;
    assign ser_word_bits  = word_bits_ff;
    assign ser_stop_code  = stop_code_ff;

    a_status_full_only: assert property (@(posedge pclk) disable iff (!presetn)
        ($fell(pp_status_n) && fifo_mode) |-> (tx.count == `UPPS_LIM_FIFO))
        else $error("status fell without a full transmit FIFO");

    a_irq_on_full: assert property (@(posedge pclk) disable iff (!presetn)
        (tx_full_rise && pp_mode && fifo_mode) |=> !pp_irq_pulse_n ##1 pp_irq_pulse_n || tx_full_rise)
        else $error("no interrupt pulse on transmit full");

    a_status_release_time: assert property (@(posedge pclk) disable iff (!presetn)
        (ack_fall && tx_st_ff == UPPS_TX_WAIT && !pp_status_n && pp_mode) |=>
            !pp_status_n [*2] ##1 pp_status_n)
        else $error("status release not three cycles after strobe edge");

    a_ack_edge_only: assert property (@(posedge pclk) disable iff (!presetn)
        (tx_st_ff == UPPS_TX_WAIT && !ack_fall && pp_mode) |=> (tx_st_ff == UPPS_TX_WAIT))
        else $error("transmit handshake advanced without a strobe edge");

    a_rx_capture: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_rise && pp_mode && !rx.full && !rx.pop) |=> (rx.count == $past(rx.count) + 5'h1))
        else $error("receive byte not captured on strobe release");

    a_rd_after_release: assert property (@(posedge pclk) disable iff (!presetn)
        (rx.empty && pp_mode && !wr_rise) |=> rx.empty || $past(wr_rise) == 1'b0 && !pp_mode)
        else $error("data ready rose without a strobe release");

    a_irq_on_empty: assert property (@(posedge pclk) disable iff (!presetn)
        (rx_empty_rise && pp_mode && fifo_mode) |=> !pp_irq_pulse_n)
        else $error("no interrupt pulse on receive empty");

    a_sideband_hold: assert property (@(posedge pclk) disable iff (!presetn)
        !sb_cond |=> $stable(sb_ff))
        else $error("side-band lines changed outside side-band mode");

    a_lstat_pp_errs: assert property (@(posedge pclk) disable iff (!presetn)
        (setup && !pwrite && paddr == `UPPS_ADDR_LSTAT && pp_mode) |=> (prdata[4:1] == 4'h0))
        else $error("error flags not zero in parallel mode");

    a_serial_off: assert property (@(posedge pclk) disable iff (!presetn)
        (pp_mode && !ser_tx_valid) |=> !ser_tx_valid)
        else $error("serial hand-off loaded in parallel mode");
endmodule
`default_nettype wire

/* File: design/upps_consts.svh */
// Offsets, field positions, reset values and timing counts of the parallel side port.
`ifndef UPPS_CONSTS_SVH
`define UPPS_CONSTS_SVH

// APB byte addresses of the host-side registers.
`define UPPS_ADDR_DATA     8'h00
`define UPPS_ADDR_LCTRL    8'h04
`define UPPS_ADDR_LSTAT    8'h08
`define UPPS_ADDR_MODE     8'h0C

// Line control fields.
`define UPPS_LC_WLS_LO     0
`define UPPS_LC_WLS_HI     1
`define UPPS_LC_NSB        2
`define UPPS_LC_RESET      3'h0

// Mode register fields.
`define UPPS_MD_PP         0
`define UPPS_MD_EXTF       1
`define UPPS_MD_FIFO       2
`define UPPS_MD_RESET      3'h0

// Line status fields.
`define UPPS_LS_RD         0
`define UPPS_LS_ERR_LO     1
`define UPPS_LS_ERR_HI     4
`define UPPS_LS_TX_HOLDING_EMPTY       5
`define UPPS_LS_TX_ALL_EMPTY       6

// FIFO geometry and limits.
`define UPPS_FIFO_DEPTH    16
`define UPPS_FIFO_AW       4
`define UPPS_CNT_W         5
`define UPPS_LIM_FIFO      5'h10
`define UPPS_LIM_BYTE      5'h01

// Timing: strobe assert to status release, at a 40 ns clock.
`define UPPS_CLK_NS        40
`define UPPS_T3_NS         150
`define UPPS_T3_CYC        ((`UPPS_T3_NS + `UPPS_CLK_NS - 1) / `UPPS_CLK_NS)
`define UPPS_SYNC_CYC      3
`define UPPS_T3_LOAD       3'((`UPPS_T3_CYC) - (`UPPS_SYNC_CYC))

// Reset values of pin-facing state.
`define UPPS_SB_RESET      8'h00
`define UPPS_WORD_BASE     4'h5

`endif

/* File: design/upps_pkg.sv */
// Types shared by the parallel side port modules.
package upps_pkg;
    typedef enum logic [1:0] {
        UPPS_TX_IDLE  = 2'b00,
        UPPS_TX_ARM   = 2'b01,
        UPPS_TX_WAIT  = 2'b10,
        UPPS_TX_DELAY = 2'b11
    } upps_tx_st_t;
endpackage

/* File: design/upps_fifo_if.sv */
// Push, pop and level signals between the port logic and one byte FIFO.
`timescale 1ns/1ps
`default_nettype none
`include "upps_consts.svh"
interface upps_fifo_if;
    logic                   push;
    logic                   pop;
    logic [7:0]             wdata;
    logic [`UPPS_CNT_W-1:0] lim;
    logic [7:0]             head;
    logic [`UPPS_CNT_W-1:0] count;
    logic                   full;
    logic                   empty;
    modport ctl (output push, pop, wdata, lim, input head, count, full, empty);
    modport mem (input push, pop, wdata, lim, output head, count, full, empty);
endinterface
`default_nettype wire

/* File: design/upps_fifo.sv */
// Sixteen-entry byte FIFO whose full level can be cut down to one byte.
`timescale 1ns/1ps
`default_nettype none
`include "upps_consts.svh"
module upps_fifo (
    input wire logic    pclk,
    input wire logic    presetn,
    upps_fifo_if.mem    fif
);
    logic [7:0]               mem_q [`UPPS_FIFO_DEPTH];
    logic [`UPPS_FIFO_AW-1:0] wr_ptr_ff;
    logic [`UPPS_FIFO_AW-1:0] rd_ptr_ff;
    logic [`UPPS_CNT_W-1:0]   cnt_ff;
    logic                     do_push;
    logic                     do_pop;

    // A push into a full FIFO and a pop from an empty one are dropped.
    assign do_push   = fif.push && !fif.full;
    assign do_pop    = fif.pop && !fif.empty;
    assign fif.full  = (cnt_ff >= fif.lim);
    assign fif.empty = (cnt_ff == '0);
    assign fif.count = cnt_ff;
    assign fif.head  = mem_q[rd_ptr_ff];

    always_ff @(posedge pclk) begin
        if (do_push) begin
            mem_q[wr_ptr_ff] <= fif.wdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            cnt_ff    <= '0;
        end else begin
            if (do_push) begin
                wr_ptr_ff <= wr_ptr_ff + 1'b1;
            end
            if (do_pop) begin
                rd_ptr_ff <= rd_ptr_ff + 1'b1;
            end
            cnt_ff <= cnt_ff + {4'h0, do_push} - {4'h0, do_pop};
        end
    end
endmodule
`default_nettype wire

/* File: bench/upps_uc_model.sv */
// Card-side microcontroller model driving the parallel port strobes and data.
`timescale 1ns/1ps
`default_nettype none
module upps_uc_model (
    input  wire logic       pclk,
    output var  logic [7:0] pp_data_in,
    output var  logic       pp_tx_ack_n,
    output var  logic       pp_rx_wr_n
);
    initial begin
        pp_data_in  = 8'h00;
        pp_tx_ack_n = 1'b1;
        pp_rx_wr_n  = 1'b1;
    end
    task automatic ack_low();
        @(posedge pclk);
        pp_tx_ack_n <= 1'b0;
    endtask
    task automatic ack_high();
        repeat (2) @(posedge pclk);
        pp_tx_ack_n <= 1'b1;
    endtask
    task automatic wr_low(input logic [7:0] b);
        @(posedge pclk);
        pp_data_in <= b;
        repeat (2) @(posedge pclk);
        pp_rx_wr_n <= 1'b0;
        repeat (2) @(posedge pclk);
    endtask
    task automatic wr_high();
        pp_rx_wr_n <= 1'b1;
        repeat (4) @(posedge pclk);
        pp_data_in <= ~pp_data_in;
        repeat (2) @(posedge pclk);
    endtask
endmodule
`default_nettype wire

/* File: bench/uart_parallel_side_port_tb_top.sv */
// Self-checking bench for the parallel side port: APB host, controller model, serial stub.
`timescale 1ns/1ps
`default_nettype none
`include "upps_consts.svh"
module uart_parallel_side_port_tb_top;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0]  paddr, pp_data_in, pp_data_lines, ser_tx_data, ser_rx_data, last_tx;
    logic [31:0] pwdata, prdata, rd;
    logic        pp_data_oe_n, pp_status_n, pp_irq_pulse_n, pp_tx_ack_n, pp_rx_wr_n;
    logic        ser_tx_valid, ser_tx_take, ser_tx_idle, ser_rx_valid;
    logic [3:0]  ser_word_bits, ser_err;
    logic [1:0]  ser_stop_code;
    int          n_mismatch, n_checks;
    int          n_irq = 0;
    int          n_take = 0;

    upps_port u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pp_data_in(pp_data_in), .pp_data_lines(pp_data_lines), .pp_data_oe_n(pp_data_oe_n),
        .pp_status_n(pp_status_n), .pp_irq_pulse_n(pp_irq_pulse_n), .pp_tx_ack_n(pp_tx_ack_n),
        .pp_rx_wr_n(pp_rx_wr_n), .ser_tx_valid(ser_tx_valid), .ser_tx_data(ser_tx_data),
        .ser_tx_take(ser_tx_take), .ser_tx_idle(ser_tx_idle), .ser_rx_valid(ser_rx_valid),
        .ser_rx_data(ser_rx_data), .ser_err(ser_err), .ser_word_bits(ser_word_bits),
        .ser_stop_code(ser_stop_code));
    upps_uc_model u_uc (.pclk(pclk), .pp_data_in(pp_data_in), .pp_tx_ack_n(pp_tx_ack_n),
        .pp_rx_wr_n(pp_rx_wr_n));

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    // The serial engine stub takes each offered character one cycle later.
    always @(posedge pclk) begin
        ser_tx_take <= (ser_tx_valid === 1'b1) && !ser_tx_take;
        if (ser_tx_take) begin
            n_take  <= n_take + 1;
            last_tx <= ser_tx_data;
        end
        if (pp_irq_pulse_n === 1'b0) n_irq <= n_irq + 1;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Samples pready at each rising edge; the request stands until the edge that sees it high.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 50);
        if (pready !== 1'b1) n_mismatch++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task automatic wait_stat(input logic v);
        int k;
        k = 0;
        while (pp_status_n !== v && k < 40) begin @(posedge pclk); k++; end
        if (pp_status_n !== v) n_mismatch++;
    endtask
    task automatic ack_byte(input logic [7:0] exp, input bit first);
        time t0;
        int  k;
        chk(pp_data_lines, exp);
        u_uc.ack_low();
        t0 = $time;
        k = 0;
        while (pp_status_n !== 1'b1 && k < 12) begin @(posedge pclk); k++; end
        // The release is seen one edge after the edge that made it.
        t0 = t0 + `UPPS_CLK_NS;
        if (first) chk({31'h0, ($time - t0 >= 150) && ($time - t0 <= 200)}, 32'h1);
        else chk(pp_status_n, 1'b1);
        u_uc.ack_high();
        repeat (6) @(posedge pclk);
    endtask

    task automatic t_sideband();
        apb(1'b1, `UPPS_ADDR_LCTRL, 32'h0000_0004);
        apb(1'b1, `UPPS_ADDR_DATA, 32'h0000_00A5);
        repeat (10) @(posedge pclk);
        chk(ser_word_bits, 4'h5);
        chk(ser_stop_code, 2'h1);
        chk(pp_data_lines, 8'hA5);
        chk(pp_data_oe_n, 1'b0);
        ser_tx_idle <= 1'b1;
        ser_err <= 4'h3;
        @(posedge pclk);
        ser_err <= 4'h0;
        apb(1'b0, `UPPS_ADDR_LSTAT, 32'h0);
        chk(rd & 32'h7F, 32'h66);
        apb(1'b1, `UPPS_ADDR_LCTRL, 32'h0000_0007);
        apb(1'b1, `UPPS_ADDR_DATA, 32'h0000_003C);
        repeat (10) @(posedge pclk);
        chk(ser_word_bits, 4'h8);
        chk(ser_stop_code, 2'h2);
        chk(pp_data_lines, 8'hA5);
        chk(last_tx, 8'h3C);
        apb(1'b1, `UPPS_ADDR_MODE, 32'h0000_0002);
        apb(1'b1, `UPPS_ADDR_LCTRL, 32'h0000_0004);
        apb(1'b1, `UPPS_ADDR_DATA, 32'h0000_0066);
        repeat (10) @(posedge pclk);
        chk(pp_data_lines, 8'hA5);
        chk(pp_data_oe_n, 1'b1);
        chk(last_tx, 8'h66);
        apb(1'b0, 8'h10, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
        $display("test sideband done");
    endtask
    task automatic t_byte();
        int base;
        base = n_take;
        apb(1'b1, `UPPS_ADDR_MODE, 32'h0000_0001);
        apb(1'b1, `UPPS_ADDR_DATA, 32'h0000_005A);
        wait_stat(1'b0);
        chk(pp_data_oe_n, 1'b0);
        ack_byte(8'h5A, 1'b1);
        // Serial receive, errors and a busy shifter must all be ignored in parallel mode.
        ser_rx_data <= 8'h99;
        ser_rx_valid <= 1'b1;
        ser_tx_idle <= 1'b0;
        ser_err <= 4'hF;
        @(posedge pclk);
        ser_rx_valid <= 1'b0;
        ser_err <= 4'h0;
        apb(1'b0, `UPPS_ADDR_LSTAT, 32'h0);
        chk(rd & 32'h7E, 32'h60);
        chk(rd[0], 1'b0);
        u_uc.wr_low(8'hC3);
        apb(1'b0, `UPPS_ADDR_LSTAT, 32'h0);
        chk(rd[0], 1'b0);
        u_uc.wr_high();
        apb(1'b0, `UPPS_ADDR_LSTAT, 32'h0);
        chk(rd[0], 1'b1);
        apb(1'b0, `UPPS_ADDR_DATA, 32'h0);
        chk(rd, 32'h0000_00C3);
        chk(n_take, base);
        $display("test byte mode done");
    endtask
    task automatic t_fifo();
        int base;
        apb(1'b1, `UPPS_ADDR_MODE, 32'h0000_0005);
        base = n_irq;
        for (int i = 0; i < 15; i++) apb(1'b1, `UPPS_ADDR_DATA, 32'h10 + i);
        repeat (8) @(posedge pclk);
        chk(pp_status_n, 1'b1);
        apb(1'b1, `UPPS_ADDR_DATA, 32'h1F);
        wait_stat(1'b0);
        chk(n_irq, base + 1);
        for (int i = 0; i < 16; i++) ack_byte(8'h10 + 8'(i), i == 0);
        chk(pp_status_n, 1'b1);
        base = n_irq;
        u_uc.wr_low(8'h81);
        u_uc.wr_high();
        u_uc.wr_low(8'h42);
        u_uc.wr_high();
        apb(1'b0, `UPPS_ADDR_DATA, 32'h0);
        chk(rd, 32'h81);
        apb(1'b0, `UPPS_ADDR_DATA, 32'h0);
        chk(rd, 32'h42);
        repeat (4) @(posedge pclk);
        chk(n_irq, base + 1);
        $display("test fifo mode done");
    endtask

    initial begin
        n_mismatch = 0; n_checks = 0;
        ser_tx_idle = 1'b0; ser_err = 4'h0; ser_rx_valid = 1'b0; ser_rx_data = 8'h00;
        psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
        presetn = 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        chk(pp_data_lines, 8'h00);
        chk({pp_status_n, pp_irq_pulse_n}, 2'b11);
        t_sideband();
        t_byte();
        t_fifo();
        print_verdict();
    end
    initial begin
        repeat (20000) @(posedge pclk);
        n_mismatch++;
        print_verdict();
    end
endmodule
`default_nettype wire
